// ---- src/acs_pkg.sv ----
// constants, types and carriers shared by the conversion sequencer
package acs_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned POR_TIME_NS   = 500000;
  localparam int unsigned CONV_TIME_NS  = 16600000;
  // "about" figures: rounded down to whole cycles
  localparam int unsigned POR_CYC_DEF   = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC_DEF  = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int          TMR_W         = 20;

  // ---------------------------------------------------------------
  // bus framing
  // ---------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR    = 7'h14;
  localparam logic       DIR_READ      = 1'h1;
  localparam logic [3:0] BITS_PER_UNIT = 4'h8;
  localparam logic [4:0] RESULT_BITS   = 5'h10;

  // ---------------------------------------------------------------
  // result coding
  // ---------------------------------------------------------------
  localparam int                 RES_W      = 16;
  localparam int                 DIFF_W     = 17;
  localparam logic signed [17:0] MIDSCALE   = 18'sh08000;
  localparam logic signed [17:0] CODE_MAX   = 18'sh0ffff;
  localparam logic signed [17:0] CODE_MIN   = 18'sh00000;
  localparam logic [15:0]        RESULT_RST = 16'h0000;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CV_POR   = 2'h0,
    CV_CONV  = 2'h1,
    CV_SLEEP = 2'h3,
    CV_DOUT  = 2'h2
  } acs_cv_state_t;

  typedef enum logic [2:0] {
    B_IDLE   = 3'h0,
    B_ADDR   = 3'h1,
    B_ACK    = 3'h3,
    B_DATA   = 3'h2,
    B_MACK   = 3'h6,
    B_IGNORE = 3'h7
  } acs_bus_phase_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } acs_line_t;

endpackage

// ---- src/acs_top.sv ----
// conversion sequencer with read-only two-wire slave readout
// Notes on behaviour
// - loop: conversion, sleep, data output, conversion
// - conversion done: sleep, reads now accepted
// - sleep holds result unchanged until addressed
// - addressed during conversion: leave line released
// - fixed slave address 0010100 only
// - match, read, ready: pull low ninth clock
// - sixteen bits out msb first, falling edges
// - sample on rising edges, clock input only
// - msb is sign, set when input non-negative
// - offset binary, midscale 32768, clamp 0..65535
// - new conversion after stop or sixteen bits
// - line released outside output; pull low only
// - internal reset interval, then conversion starts
// - start and stop detected while clock high
// - repeated start handled exactly as start
// - units of eight bits plus acknowledge
// - data changes only while clock low
// - slave only, transmits latest result only
// - stop after acknowledged read discards result
`timescale 1ns/1ps
`default_nettype none

module acs_top
  import acs_pkg::*;
#(
  parameter int unsigned POR_CYC  = POR_CYC_DEF,
  parameter int unsigned CONV_CYC = CONV_CYC_DEF
) (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_scl,
  input  wire logic                     i_sda,
  input  wire logic signed [DIFF_W-1:0] i_mod_diff,
  output logic                          o_sda_o,
  output logic                          o_sda_oe,
  output acs_cv_state_t                 o_conv_state
);

  localparam logic [TMR_W-1:0] POR_LAST  = TMR_W'(POR_CYC - 1);
  localparam logic [TMR_W-1:0] CONV_LAST = TMR_W'(CONV_CYC - 1);

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  acs_line_t s1_q, s1_d;
  acs_line_t s2_q, s2_d;
  acs_line_t s3_q, s3_d;

  always_comb begin
    s1_d = '{scl: i_scl, sda: i_sda};
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // idle bus level is high, so reset to released lines
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s1_q <= '{scl: 1'h1, sda: 1'h1};
      s2_q <= '{scl: 1'h1, sda: 1'h1};
      s3_q <= '{scl: 1'h1, sda: 1'h1};
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // only stage two and three are looked at
  assign scl_rise   = s2_q.scl & ~s3_q.scl;
  assign scl_fall   = ~s2_q.scl & s3_q.scl;
  assign start_seen = s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
  assign stop_seen  = s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;

  // ---------------------------------------------------------------
  // result coding
  // ---------------------------------------------------------------
  logic signed [17:0] code_raw;
  logic [RES_W-1:0]   code_sat;

  always_comb begin
    code_raw = 18'(i_mod_diff) + MIDSCALE;
    if (code_raw > CODE_MAX) begin
      code_sat = CODE_MAX[RES_W-1:0];
    end else if (code_raw < CODE_MIN) begin
      code_sat = CODE_MIN[RES_W-1:0];
    end else begin
      code_sat = code_raw[RES_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // sequencer and slave port
  // ---------------------------------------------------------------
  acs_cv_state_t    cv_q, cv_d;
  acs_bus_phase_t   ph_q, ph_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [3:0]       bcnt_q, bcnt_d;
  logic [4:0]       sent_q, sent_d;
  logic [7:0]       ashift_q, ashift_d;
  logic [RES_W-1:0] dshift_q, dshift_d;
  logic [RES_W-1:0] result_q, result_d;
  logic             oe_q, oe_d;
  logic             sda_o_q;
  logic             addr_ok;

  // a repeated start may re-read while still in output state
  assign addr_ok = (ashift_q[7:1] == SLAVE_ADDR)
                 && (ashift_q[0] == DIR_READ)
                 && ((cv_q == CV_SLEEP) || (cv_q == CV_DOUT));

  always_comb begin
    cv_d     = cv_q;
    ph_d     = ph_q;
    tmr_d    = tmr_q;
    bcnt_d   = bcnt_q;
    sent_d   = sent_q;
    ashift_d = ashift_q;
    dshift_d = dshift_q;
    result_d = result_q;
    oe_d     = oe_q;

    case (cv_q)
      CV_POR: begin
        if (tmr_q == POR_LAST) begin
          cv_d  = CV_CONV;
          tmr_d = '0;
        end else begin
          tmr_d = tmr_q + 1'h1;
        end
      end
      CV_CONV: begin
        if (tmr_q == CONV_LAST) begin
          cv_d     = CV_SLEEP;
          tmr_d    = '0;
          result_d = code_sat;
        end else begin
          tmr_d = tmr_q + 1'h1;
        end
      end
      default: begin
      end
    endcase

    if (start_seen) begin
      ph_d   = B_ADDR;
      bcnt_d = '0;
      oe_d   = 1'h0;
    end else if (stop_seen) begin
      ph_d = B_IDLE;
      oe_d = 1'h0;
      if (cv_q == CV_DOUT) begin
        cv_d  = CV_CONV;
        tmr_d = '0;
      end
    end else begin
      case (ph_q)
        B_ADDR: begin
          if (scl_rise) begin
            ashift_d = {ashift_q[6:0], s2_q.sda};
            bcnt_d   = bcnt_q + 1'h1;
          end else if (scl_fall && (bcnt_q == BITS_PER_UNIT)) begin
            if (addr_ok) begin
              oe_d     = 1'h1;
              ph_d     = B_ACK;
              cv_d     = CV_DOUT;
              dshift_d = result_q;
              sent_d   = '0;
            end else begin
              ph_d = B_IGNORE;
            end
          end
        end
        B_ACK, B_MACK: begin
          if (scl_fall) begin
            oe_d     = ~dshift_q[RES_W-1];
            dshift_d = {dshift_q[RES_W-2:0], 1'h0};
            sent_d   = sent_q + 1'h1;
            bcnt_d   = '0;
            ph_d     = B_DATA;
          end
        end
        B_DATA: begin
          if (scl_rise) begin
            bcnt_d = bcnt_q + 1'h1;
          end else if (scl_fall) begin
            if (bcnt_q == BITS_PER_UNIT) begin
              oe_d = 1'h0;
              if (sent_q == RESULT_BITS) begin
                cv_d  = CV_CONV;
                tmr_d = '0;
                ph_d  = B_IGNORE;
              end else begin
                ph_d = B_MACK;
              end
            end else begin
              oe_d     = ~dshift_q[RES_W-1];
              dshift_d = {dshift_q[RES_W-2:0], 1'h0};
              sent_d   = sent_q + 1'h1;
            end
          end
        end
        default: begin
          oe_d = 1'h0;
        end
      endcase
    end
  end

  // sleep leaves result_q and dshift_q untouched indefinitely
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cv_q     <= CV_POR;
      ph_q     <= B_IDLE;
      tmr_q    <= '0;
      bcnt_q   <= '0;
      sent_q   <= '0;
      ashift_q <= '0;
      dshift_q <= RESULT_RST;
      result_q <= RESULT_RST;
      oe_q     <= 1'h0;
      sda_o_q  <= 1'h0;
    end else begin
      cv_q     <= cv_d;
      ph_q     <= ph_d;
      tmr_q    <= tmr_d;
      bcnt_q   <= bcnt_d;
      sent_q   <= sent_d;
      ashift_q <= ashift_d;
      dshift_q <= dshift_d;
      result_q <= result_d;
      oe_q     <= oe_d;
      sda_o_q  <= 1'h0;
    end
  end

  assign o_sda_o      = sda_o_q;
  assign o_sda_oe     = oe_q;
  assign o_conv_state = cv_q;

endmodule

`default_nettype wire

// ---- verification/acs_props.sv ----
// concurrent checks on the sequencer pins
`timescale 1ns/1ps
`default_nettype none
module acs_props
  import acs_pkg::*;
#(
  parameter int unsigned POR_CYC  = 20,
  parameter int unsigned CONV_CYC = 200
) (
  input wire logic                     i_ref_clk,
  input wire logic                     i_rst_n,
  input wire logic                     i_scl,
  input wire logic                     i_sda,
  input wire logic signed [DIFF_W-1:0] i_mod_diff,
  input wire logic                     o_sda_o,
  input wire logic                     o_sda_oe,
  input wire acs_cv_state_t            o_conv_state
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // length of the current conversion run
  logic [19:0] run_q;
  logic [19:0] run_d;
  always_comb begin
    run_d = (!i_rst_n || o_conv_state != CV_CONV) ? 20'h0 : run_q + 20'h1;
  end
  always_ff @(posedge i_ref_clk) begin
    run_q <= run_d;
  end
  AST_ODRAIN: assert property (o_sda_o == 1'b0)
    else $error("data pin driven high");
  AST_OE_STATE: assert property (o_sda_oe |-> (o_conv_state == CV_SLEEP || o_conv_state == CV_DOUT))
    else $error("data pulled while not ready");
  AST_POR_EXIT: assert property ((o_conv_state == CV_POR ##1 o_conv_state != CV_POR) |-> o_conv_state == CV_CONV)
    else $error("reset interval not followed by conversion");
  AST_CONV_EXIT: assert property ((o_conv_state == CV_CONV ##1 o_conv_state != CV_CONV) |-> o_conv_state == CV_SLEEP)
    else $error("conversion not followed by sleep");
  AST_SLEEP_EXIT: assert property ((o_conv_state == CV_SLEEP ##1 o_conv_state != CV_SLEEP) |-> o_conv_state == CV_DOUT)
    else $error("sleep left without output");
  AST_DOUT_EXIT: assert property ((o_conv_state == CV_DOUT ##1 o_conv_state != CV_DOUT) |-> o_conv_state == CV_CONV)
    else $error("output not followed by conversion");
  AST_DOUT_REL: assert property ((o_conv_state == CV_DOUT ##1 o_conv_state == CV_CONV) |-> !o_sda_oe)
    else $error("data line held after output");
  AST_CONV_LEN: assert property ((o_conv_state != CV_CONV && run_q != 20'h0) |-> run_q == CONV_CYC)
    else $error("conversion length wrong");
  AST_RESET_OUT: assert property ($rose(i_rst_n) |-> (o_conv_state == CV_POR && !o_sda_oe))
    else $error("outputs not cleared by reset");
endmodule
bind acs_top acs_props #(.POR_CYC(POR_CYC), .CONV_CYC(CONV_CYC)) acs_props_inst (.i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .i_mod_diff(i_mod_diff), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_conv_state(o_conv_state));
`default_nettype wire

// ---- verification/acs_master.sv ----
// two-wire bus master model, 200 ns serial clock
`timescale 1ns/1ps
`default_nettype none
module acs_master (
  output logic      o_scl,
  output logic      o_sda_pull,
  input  wire logic i_sda
);
  // clock idles high, stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  // long low phase lets the slave release its ack first
  task automatic start();
    #20 o_sda_pull = 1'b0;
    #180 o_scl = 1'b1;
    #50 o_sda_pull = 1'b1;
    #50 o_scl = 1'b0;
  endtask
  task automatic stop();
    #20 o_sda_pull = 1'b1;
    #80 o_scl = 1'b1;
    #50 o_sda_pull = 1'b0;
    #100;
  endtask
  // data moves only while clock low; sampled late in the high phase
  task automatic clk_bit(input logic b, output logic s);
    #20 o_sda_pull = ~b;
    #80 o_scl = 1'b1;
    #80 s = i_sda;
    #20 o_scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] v, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
    clk_bit(1'b1, nak);
  endtask
  task automatic recv(output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, v[i]);
    clk_bit(1'b1, s);
  endtask
endmodule
`default_nettype wire

// ---- verification/adc_conversion_sequencer_i2c_readout_bench.sv ----
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_i2c_readout_bench;
  import acs_pkg::*;
  logic                clk;
  logic                rst_n;
  logic signed [16:0]  diff;
  logic                scl;
  logic                pull;
  logic                oe;
  logic                sdo;
  acs_cv_state_t       st;
  logic [15:0]         e;
  logic [6:0]          a;
  wire logic           sda = ~(pull | oe);
  int                  bad_count = 0;
  int                  compares = 0;
  int                  seed = 32'hc515c2eb;
  logic signed [16:0]  corner [4] = '{17'h17fff, 17'h07fff, 17'h1ffff, 17'h08000};
  acs_top #(.POR_CYC(20), .CONV_CYC(200)) acs_top_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_scl(scl),
    .i_sda(sda), .i_mod_diff(diff), .o_sda_o(sdo), .o_sda_oe(oe), .o_conv_state(st));
  acs_master acs_master_inst (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] exp_code(input int d);
    int v;
    v = d + 32768;
    return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : v[15:0];
  endfunction
  task automatic wait_state(input acs_cv_state_t s);
    int n;
    n = 0;
    while (st !== s && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(16'(st), 16'(s));
  endtask
  task automatic addr(input logic [7:0] b, input logic exp_nak);
    logic nak;
    acs_master_inst.start();
    acs_master_inst.send(b, nak);
    chk(16'(nak), 16'(exp_nak));
  endtask
  task automatic read_all(input logic [15:0] exp);
    logic [7:0] hi;
    logic [7:0] lo;
    addr({SLAVE_ADDR, DIR_READ}, 1'b0);
    acs_master_inst.recv(hi);
    acs_master_inst.recv(lo);
    chk({hi, lo}, exp);
    repeat (4) @(posedge clk);
    chk(16'(st), 16'(CV_CONV));
    acs_master_inst.stop();
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    diff = 17'h00000;
    repeat (16) @(posedge clk);
    #2 rst_n = 1'b1;
    addr({SLAVE_ADDR, DIR_READ}, 1'b1);
    acs_master_inst.stop();
    wait_state(CV_SLEEP);
    read_all(16'h8000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #2 diff = (i < 4) ? corner[i] : $signed(16'($random(seed)));
      e = exp_code(int'(diff));
      wait_state(CV_SLEEP);
      #2 diff = 17'($random(seed));
      a = 7'($random(seed));
      if (a == SLAVE_ADDR) a = a ^ 7'h01;
      addr({a, DIR_READ}, 1'b1);
      acs_master_inst.stop();
      addr({SLAVE_ADDR, ~DIR_READ}, 1'b1);
      acs_master_inst.stop();
      repeat (50) @(posedge clk);
      chk(16'(st), 16'(CV_SLEEP));
      read_all(e);
    end
    // mid-run reset while converting: sequencer must restart from the reset interval
    @(posedge clk);
    #2 rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #2 rst_n = 1'b1;
    chk(16'(st), 16'(CV_POR));
    chk(16'(oe), 16'h0000);
    // positive input keeps the sign bit released, so stop and restart stay visible
    @(posedge clk);
    #2 diff = 17'h04000;
    wait_state(CV_SLEEP);
    addr({SLAVE_ADDR, DIR_READ}, 1'b0);
    acs_master_inst.stop();
    repeat (4) @(posedge clk);
    chk(16'(st), 16'(CV_CONV));
    wait_state(CV_SLEEP);
    addr({SLAVE_ADDR, DIR_READ}, 1'b0);
    read_all(16'hc000);
    print_verdict();
  end
  initial begin
    #500000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
